// *** dv/pec_host.sv ***
// Host bus master model for the power event control block.
// Assumes the caller returns just after a rising clock edge.
`timescale 1ns/1ps
module pec_host (
  input wire logic clock_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [3:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o
);
  initial begin
    address_o = 4'h0;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
  end
  // Request held until waitrequest seen low; an idle edge follows
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    address_o <= a;
    writedata_o <= d;
    read_o <= rd;
    write_o <= !rd;
    @(posedge clock_i);
    while (waitrequest_i !== 1'b0) @(posedge clock_i);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    @(posedge clock_i);
  endtask
endmodule // pec_host

// *** dv/pec_properties.sv ***
// Port checker for the power event control block.
// Assumes bound to pec_top, single clock domain.
`timescale 1ns/1ps
module pec_properties (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic analog_supply_pin_above_low_i,
  input wire logic vsense_above_high_i,
  input wire logic power_key_i,
  input wire logic analog_demand_i,
  input wire logic dual_phase_o,
  input wire logic multi_phase_on_o,
  input wire logic ldo_en_o,
  input wire logic ldo_bypass_o,
  input wire logic analog_ldo_en_o,
  input wire logic int_rst_n_o,
  input wire logic all_clk_en_o,
  input wire logic clk32_en_o,
  input wire logic wake_func_en_o,
  input wire logic turn_on_detect_en_o,
  input wire pec_pkg::pec_state_t state_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  sequence req_s; (read_i || write_i) && waitrequest_o; endsequence
  sequence ack_s; !waitrequest_o ##1 waitrequest_o; endsequence
  chk_bus_ack_once: assert property (req_s |=> ack_s) else $error("bus ack not one cycle");
  chk_read_upper_zero: assert property (read_i && !waitrequest_o |-> readdata_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_analog_rail_on: assert property ($rose(analog_demand_i) |-> ##[1:3] analog_ldo_en_o)
    else $error("analog rail not enabled");
  chk_analog_rail_off: assert property ($fell(analog_demand_i) |-> ##[1:3] !analog_ldo_en_o)
    else $error("analog rail not disabled");
  chk_active_clocks: assert property (all_clk_en_o == (state_o == pec_pkg::PEC_ACTIVE))
    else $error("all clocks not tied to active");
  chk_reset_clk32: assert property (clk32_en_o == int_rst_n_o
    && int_rst_n_o == (state_o inside {pec_pkg::PEC_ACTIVE, pec_pkg::PEC_SLEEP}))
    else $error("reset or slow clock wrong for state");
  chk_turn_on_det: assert property (wake_func_en_o && turn_on_detect_en_o == (state_o == pec_pkg::PEC_OFF))
    else $error("wake or turn-on detect wrong");
  chk_single_phase: assert property (!dual_phase_o |-> !multi_phase_on_o)
    else $error("multiphase without dual phase");
  chk_bypass_en: assert property (ldo_bypass_o |-> ldo_en_o) else $error("bypass while disabled");
  chk_low_backup: assert property (!analog_supply_pin_above_low_i [*3] |-> state_o == pec_pkg::PEC_BACKUP)
    else $error("not backup on low supply");
  chk_active_high: assert property (state_o == pec_pkg::PEC_ACTIVE && $past(state_o) == pec_pkg::PEC_OFF
    |-> $past(vsense_above_high_i, 2)) else $error("active without high sense");
  chk_off_by_key: assert property (state_o == pec_pkg::PEC_OFF
    && $past(state_o) inside {pec_pkg::PEC_ACTIVE, pec_pkg::PEC_SLEEP} |-> $past(power_key_i, 3))
    else $error("switched off without key held");
endmodule // pec_properties
bind pec_top pec_properties i_props (.*);

// *** dv/tb.sv ***
// Testbench for pec_top: host model on the bus, random phase and rail stimulus.
// Assumes long-press times set to 1 ms each, 40000 cycles at 40 MHz.
`timescale 1ns/1ps
module tb;
  localparam int HOLD = 40000;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] address_i;
  logic read_i;
  logic write_i;
  logic [31:0] writedata_i;
  logic [3:0] byteenable_i = 4'hF;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic otp_dual_phase_i = 1'b1;
  pec_pkg::pec_int_t otp_int_mask_i = 2'h2;
  logic hw_reset_event_i = 1'b0;
  logic high_load_i = 1'b0;
  logic analog_demand_i = 1'b0;
  logic analog_supply_pin_above_low_i = 1'b0;
  logic vsense_above_high_i = 1'b0;
  logic power_key_i = 1'b0;
  logic dual_phase_o, multi_phase_on_o, ldo_en_o, ldo_bypass_o, analog_ldo_en_o, always_on_normal_o;
  logic int_rst_n_o, all_clk_en_o, clk32_en_o, wake_func_en_o, turn_on_detect_en_o, irq_o;
  logic [5:0] ldo_vsel_o;
  pec_pkg::pec_state_t state_o;
  int fails = 0;
  int n_checks = 0;
  int seed = 32'h4d448847;
  always #12.5 clock_i = ~clock_i;
  pec_top #(.LPK_MS0(1), .LPK_MS1(1), .LPK_MS2(1), .LPK_MS3(1)) i_dut (.*);
  pec_host i_host (.clock_i(clock_i), .waitrequest_i(waitrequest_o), .readdata_i(readdata_o),
    .address_o(address_i), .read_o(read_i), .write_o(write_i), .writedata_o(writedata_i));
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b0, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b1, a, 32'h0, q);
    cmp(nm, e, q);
  endtask
  task automatic wait_state(input pec_pkg::pec_state_t s);
    for (int i = 0; i < 60 && state_o !== s; i++) @(posedge clock_i);
  endtask
  function automatic logic exp_multi(input logic dp, input logic [1:0] f, input logic hl);
    return dp & (f == pec_pkg::PHASE_MULTI || (f != pec_pkg::PHASE_SINGLE && hl));
  endfunction
  task automatic conclude();
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clock_i);
    fails++;
    conclude();
  end
  initial begin
    logic [1:0] f;
    logic [1:0] sel;
    logic seen;
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    rdc("status", pec_pkg::ADDR_PWR_STATUS, 32'h0);
    rdc("ldo", pec_pkg::ADDR_LDO_CTRL, {24'h0, pec_pkg::LDO_VSEL_RST, 2'h0});
    rdc("mask", pec_pkg::ADDR_INT_MASK, 32'h3);
    rdc("unmapped", 4'hF, 32'h0);
    hw_reset_event_i <= 1'b1;
    @(posedge clock_i);
    hw_reset_event_i <= 1'b0;
    @(posedge clock_i);
    rdc("mask", pec_pkg::ADDR_INT_MASK, 32'h2);
    sel = 2'($random(seed));
    wr(pec_pkg::ADDR_PWR_CFG, {29'h0, sel, 1'b1});
    analog_supply_pin_above_low_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    cmp("irq", 32'h1, irq_o);
    cmp("state", pec_pkg::PEC_OFF, state_o);
    rdc("sec_int", pec_pkg::ADDR_SEC_INT, 32'h1);
    rdc("int_status", pec_pkg::ADDR_INT_STATUS, 32'h0);
    vsense_above_high_i <= 1'b1;
    wait_state(pec_pkg::PEC_ACTIVE);
    cmp("auto_start", pec_pkg::PEC_ACTIVE, state_o);
    // Fallback start keeps the rest of the run useful
    power_key_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    power_key_i <= 1'b0;
    wait_state(pec_pkg::PEC_ACTIVE);
    cmp("active", 32'hF, {int_rst_n_o, all_clk_en_o, clk32_en_o, always_on_normal_o});
    wr(pec_pkg::ADDR_PWR_CFG, {29'h1, sel, 1'b1});
    wait_state(pec_pkg::PEC_SLEEP);
    cmp("sleep", 32'h5, {int_rst_n_o, all_clk_en_o, clk32_en_o});
    wr(pec_pkg::ADDR_PWR_CFG, {29'h0, sel, 1'b1});
    wait_state(pec_pkg::PEC_ACTIVE);
    for (int i = 0; i < 12; i++) begin
      f = (i < 4) ? 2'(i) : 2'($random(seed));
      otp_dual_phase_i <= (i < 4) | 1'($random(seed));
      high_load_i <= (f == pec_pkg::PHASE_MULTI) | 1'($random(seed));
      analog_demand_i <= 1'($random(seed));
      wr(pec_pkg::ADDR_CONV_CTRL, {30'h0, f});
      repeat (3) @(posedge clock_i);
      cmp("multi", exp_multi(otp_dual_phase_i, f, high_load_i), multi_phase_on_o);
      cmp("dual", otp_dual_phase_i, dual_phase_o);
      cmp("analog", analog_demand_i, analog_ldo_en_o);
    end
    wr(pec_pkg::ADDR_LDO_CTRL, {24'h0, 6'h10, 2'h3});
    repeat (2) @(posedge clock_i);
    cmp("bypass", {2'h3, 6'h10}, {ldo_en_o, ldo_bypass_o, ldo_vsel_o});
    wr(pec_pkg::ADDR_LDO_CTRL, {24'h0, 6'h10, 2'h0});
    wr(pec_pkg::ADDR_LDO_CTRL, {24'h0, 6'h1C, 2'h1});
    repeat (2) @(posedge clock_i);
    cmp("range", {2'h2, 6'h1C}, {ldo_en_o, ldo_bypass_o, ldo_vsel_o});
    power_key_i <= 1'b1;
    repeat (HOLD - 10) @(posedge clock_i);
    power_key_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    cmp("short_press", pec_pkg::PEC_ACTIVE, state_o);
    wr(pec_pkg::ADDR_INT_MASK, 32'h0);
    power_key_i <= 1'b1;
    repeat (HOLD - 5) @(posedge clock_i);
    cmp("long_early", pec_pkg::PEC_ACTIVE, state_o);
    seen = 1'b0;
    for (int i = 0; i < 12 && state_o !== pec_pkg::PEC_OFF; i++) begin
      seen |= irq_o;
      @(posedge clock_i);
    end
    cmp("irq_first", 32'h1, seen);
    cmp("long_off", pec_pkg::PEC_OFF, state_o);
    power_key_i <= 1'b0;
    rdc("int_status", pec_pkg::ADDR_INT_STATUS, 32'h2);
    wr(pec_pkg::ADDR_SEC_INT, 32'h2);
    wr(pec_pkg::ADDR_PWR_CFG, 32'h0);
    analog_supply_pin_above_low_i <= 1'b0;
    repeat (5) @(posedge clock_i);
    cmp("backup", {pec_pkg::PEC_BACKUP, 3'h2}, {state_o, turn_on_detect_en_o, wake_func_en_o, always_on_normal_o});
    analog_supply_pin_above_low_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    cmp("masked_irq", 32'h0, irq_o);
    cmp("masked_wake", pec_pkg::PEC_OFF, state_o);
    rdc("sec_int", pec_pkg::ADDR_SEC_INT, 32'h2);
    conclude();
  end
endmodule // tb

// *** rtl/pec_pkg.sv ***
// Package for the power event control block: register map, fields, states.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register bus.
package pec_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;

  localparam logic [3:0] ADDR_CONV_CTRL = 4'h0;
  localparam logic [3:0] ADDR_LDO_CTRL = 4'h1;
  localparam logic [3:0] ADDR_PWR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_SEC_INT = 4'h3;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h4;
  localparam logic [3:0] ADDR_INT_MASK = 4'h5;
  localparam logic [3:0] ADDR_PWR_CFG = 4'h6;

  localparam logic [1:0] PHASE_AUTO = 2'h0;
  localparam logic [1:0] PHASE_MULTI = 2'h1;
  localparam logic [1:0] PHASE_SINGLE = 2'h2;

  localparam int unsigned LDO_EN_BIT = 0;
  localparam int unsigned LDO_BYP_BIT = 1;
  localparam int unsigned LDO_VSEL_LSB = 2;
  localparam logic [5:0] LDO_VSEL_UPPER = 6'h1A;
  localparam logic [5:0] LDO_VSEL_RST = 6'h12;

  localparam int unsigned SEC_FLAG_BIT = 0;
  localparam int unsigned SEC_MASK_BIT = 1;

  localparam int unsigned CFG_AUTO_BIT = 0;
  localparam int unsigned CFG_LPK_LSB = 1;
  localparam int unsigned CFG_SLEEP_BIT = 3;
  localparam logic [1:0] CFG_LPK_RST = 2'h0;

  typedef struct packed {
    logic long_press;
    logic first_supply;
  } pec_int_t;

  typedef enum logic [1:0] {
    PEC_BACKUP,
    PEC_OFF,
    PEC_ACTIVE,
    PEC_SLEEP
  } pec_state_t;

endpackage

// *** rtl/pec_top.sv ***
// Power event control: phase select, LDO control, power states, wake and key events.
// Assumes all inputs synchronous to clock_i; registers on Avalon-MM with waitrequest.
`timescale 1ns/1ps

// Functional notes
// - OTP bit picks single or dual phase
// - Auto phase by load, or forced by field
// - ACTIVE all clocks, SLEEP only 32 kHz
// - Analog rail follows analog demand in ACTIVE and SLEEP
// - BACKUP wake only, OFF adds turn-on detect
// - Bypass LDO pair supports bypass mode
// - Auto start powers up on supply
// - Event above low, ACTIVE above high
// - Unmasked first-supply event raises interrupt
// - First-supply flag in secondary register
// - Unmasked first-supply interrupt wakes state machine
// - Hardware reset reloads masks from OTP
// - Mask bit suppresses interrupt and wake
// - Long press raises interrupt then powers off
// - Press-duration field selects hold time
module pec_top #(
  parameter int unsigned LPK_MS0 = 6000,
  parameter int unsigned LPK_MS1 = 8000,
  parameter int unsigned LPK_MS2 = 10000,
  parameter int unsigned LPK_MS3 = 12000
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic otp_dual_phase_i,
  input wire pec_pkg::pec_int_t otp_int_mask_i,
  input wire logic hw_reset_event_i,
  input wire logic high_load_i,
  input wire logic analog_demand_i,
  input wire logic analog_supply_pin_above_low_i,
  input wire logic vsense_above_high_i,
  input wire logic power_key_i,
  output logic dual_phase_o,
  output logic multi_phase_on_o,
  output logic ldo_en_o,
  output logic ldo_bypass_o,
  output logic [5:0] ldo_vsel_o,
  output logic analog_ldo_en_o,
  output logic always_on_normal_o,
  output logic int_rst_n_o,
  output logic all_clk_en_o,
  output logic clk32_en_o,
  output logic wake_func_en_o,
  output logic turn_on_detect_en_o,
  output pec_pkg::pec_state_t state_o,
  output logic irq_o
);

  localparam int unsigned CYC_PER_MS = pec_pkg::CLK_HZ / 1000;
  localparam logic [31:0] LPK_CYC0 = 32'(LPK_MS0 * CYC_PER_MS);
  localparam logic [31:0] LPK_CYC1 = 32'(LPK_MS1 * CYC_PER_MS);
  localparam logic [31:0] LPK_CYC2 = 32'(LPK_MS2 * CYC_PER_MS);
  localparam logic [31:0] LPK_CYC3 = 32'(LPK_MS3 * CYC_PER_MS);

  pec_pkg::pec_state_t state;
  pec_pkg::pec_int_t int_status;
  pec_pkg::pec_int_t int_mask;
  pec_pkg::pec_int_t next_set;
  logic [1:0] phase_force;
  logic ldo_en;
  logic ldo_bypass;
  logic [5:0] ldo_vsel;
  logic auto_start;
  logic [1:0] lpk_sel;
  logic sleep_req;
  logic analog_supply_pin_q;
  logic key_q;
  logic start_pending;
  logic off_pending;
  logic [31:0] lpk_cnt;
  logic [31:0] lpk_target;
  logic [31:0] next_rdata;
  logic req_take;
  logic wr_ok;
  logic rd_ok;
  logic fsd_event;
  logic fsd_wake;
  logic lpk_hit;
  logic key_rise;
  logic [5:0] wr_vsel;
  logic wr_en;
  logic range_cross;
  logic run_state;
  logic fsd_irq_pend;

  // One wait cycle on every access; the access acts on the edge waitrequest is low
  assign req_take = (read_i | write_i) & waitrequest_o;
  assign wr_ok = write_i & ~waitrequest_o & byteenable_i[0];
  assign rd_ok = read_i & ~waitrequest_o;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      waitrequest_o <= 1'b1;
    end else begin
      waitrequest_o <= ~req_take;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (address_i)
      pec_pkg::ADDR_CONV_CTRL: next_rdata = {26'h0, multi_phase_on_o, dual_phase_o, 2'h0, phase_force};
      pec_pkg::ADDR_LDO_CTRL: next_rdata = {24'h0, ldo_vsel, ldo_bypass, ldo_en};
      pec_pkg::ADDR_PWR_STATUS: next_rdata = {24'h0, always_on_normal_o, analog_ldo_en_o, clk32_en_o,
                                              all_clk_en_o, int_rst_n_o, start_pending, state};
      pec_pkg::ADDR_SEC_INT: next_rdata = {30'h0, int_mask.first_supply, int_status.first_supply};
      pec_pkg::ADDR_INT_STATUS: next_rdata = {30'h0, int_status};
      pec_pkg::ADDR_INT_MASK: next_rdata = {30'h0, int_mask};
      pec_pkg::ADDR_PWR_CFG: next_rdata = {28'h0, sleep_req, lpk_sel, auto_start};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (req_take & read_i) begin
      readdata_o <= next_rdata;
    end
  end

  // Converter control
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      phase_force <= pec_pkg::PHASE_AUTO;
    end else if (wr_ok && address_i == pec_pkg::ADDR_CONV_CTRL) begin
      phase_force <= writedata_i[1:0];
    end
  end

  // Forcing multiphase at no load is left to software; no guard here
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dual_phase_o <= 1'b0;
      multi_phase_on_o <= 1'b0;
    end else begin
      dual_phase_o <= otp_dual_phase_i;
      unique case (phase_force)
        pec_pkg::PHASE_MULTI: multi_phase_on_o <= otp_dual_phase_i;
        pec_pkg::PHASE_SINGLE: multi_phase_on_o <= 1'b0;
        default: multi_phase_on_o <= otp_dual_phase_i & high_load_i;
      endcase
    end
  end

  // LDO control; a range change while enabled and kept enabled is dropped, enable and bypass bits still apply
  assign wr_vsel = writedata_i[pec_pkg::LDO_VSEL_LSB +: 6];
  assign wr_en = writedata_i[pec_pkg::LDO_EN_BIT];
  assign range_cross = (wr_vsel >= pec_pkg::LDO_VSEL_UPPER) != (ldo_vsel >= pec_pkg::LDO_VSEL_UPPER);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ldo_en <= 1'b0;
      ldo_bypass <= 1'b0;
      ldo_vsel <= pec_pkg::LDO_VSEL_RST;
    end else if (wr_ok && address_i == pec_pkg::ADDR_LDO_CTRL) begin
      ldo_en <= wr_en;
      ldo_bypass <= writedata_i[pec_pkg::LDO_BYP_BIT];
      if (!(ldo_en && wr_en && range_cross)) begin
        ldo_vsel <= wr_vsel;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ldo_en_o <= 1'b0;
      ldo_bypass_o <= 1'b0;
      ldo_vsel_o <= pec_pkg::LDO_VSEL_RST;
    end else begin
      ldo_en_o <= ldo_en;
      ldo_bypass_o <= ldo_en & ldo_bypass;
      ldo_vsel_o <= ldo_vsel;
    end
  end

  // Power configuration
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      auto_start <= 1'b0;
      lpk_sel <= pec_pkg::CFG_LPK_RST;
      sleep_req <= 1'b0;
    end else if (wr_ok && address_i == pec_pkg::ADDR_PWR_CFG) begin
      auto_start <= writedata_i[pec_pkg::CFG_AUTO_BIT];
      lpk_sel <= writedata_i[pec_pkg::CFG_LPK_LSB +: 2];
      sleep_req <= writedata_i[pec_pkg::CFG_SLEEP_BIT];
    end
  end

  // Event detection
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      analog_supply_pin_q <= 1'b0;
      key_q <= 1'b0;
    end else begin
      analog_supply_pin_q <= analog_supply_pin_above_low_i;
      key_q <= power_key_i;
    end
  end

  assign fsd_event = analog_supply_pin_above_low_i & ~analog_supply_pin_q;
  assign fsd_wake = fsd_event & ~int_mask.first_supply;
  assign key_rise = power_key_i & ~key_q;

  // Running means internal reset released
  assign run_state = state == pec_pkg::PEC_ACTIVE || state == pec_pkg::PEC_SLEEP;

  // A pending unmasked first-supply interrupt also wakes SLEEP
  assign fsd_irq_pend = int_status.first_supply & ~int_mask.first_supply;

  always_comb begin
    unique case (lpk_sel)
      2'h0: lpk_target = LPK_CYC0;
      2'h1: lpk_target = LPK_CYC1;
      2'h2: lpk_target = LPK_CYC2;
      2'h3: lpk_target = LPK_CYC3;
    endcase
  end

  assign lpk_hit = power_key_i && lpk_cnt == lpk_target - 32'h0000_0001 &&
                   (state == pec_pkg::PEC_ACTIVE || state == pec_pkg::PEC_SLEEP);

  // Counts only a continuous hold while on; a release starts over
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      lpk_cnt <= 32'h0000_0000;
    end else if (!power_key_i || lpk_hit) begin
      lpk_cnt <= 32'h0000_0000;
    end else if (state == pec_pkg::PEC_ACTIVE || state == pec_pkg::PEC_SLEEP) begin
      lpk_cnt <= lpk_cnt + 32'h0000_0001;
    end
  end

  // Interrupt status and masks
  always_comb begin
    next_set.first_supply = fsd_event & ~int_mask.first_supply;
    next_set.long_press = lpk_hit;
  end

  // A set in the clearing cycle wins
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      int_status <= '0;
    end else if (rd_ok && address_i == pec_pkg::ADDR_INT_STATUS) begin
      int_status <= next_set;
    end else if (rd_ok && address_i == pec_pkg::ADDR_SEC_INT) begin
      int_status.first_supply <= next_set.first_supply;
      int_status.long_press <= int_status.long_press | next_set.long_press;
    end else begin
      int_status <= int_status | next_set;
    end
  end

  // The OTP mask is caught on a clocked edge, never loaded by the reset itself
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      int_mask <= '1;
    end else if (hw_reset_event_i) begin
      int_mask <= otp_int_mask_i;
    end else if (wr_ok && address_i == pec_pkg::ADDR_INT_MASK) begin
      int_mask <= writedata_i[1:0];
    end else if (wr_ok && address_i == pec_pkg::ADDR_SEC_INT) begin
      int_mask.first_supply <= writedata_i[pec_pkg::SEC_MASK_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(int_status & ~int_mask);
    end
  end

  // Power state machine
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      start_pending <= 1'b0;
    end else if (!analog_supply_pin_above_low_i || run_state) begin
      start_pending <= 1'b0;
    // A first-supply event meets the machine in BACKUP, so the start is kept through OFF until ACTIVE or SLEEP
    end else if ((fsd_event && auto_start) || fsd_wake ||
                 (key_rise && state == pec_pkg::PEC_OFF)) begin
      start_pending <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      off_pending <= 1'b0;
    end else begin
      off_pending <= lpk_hit;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= pec_pkg::PEC_BACKUP;
    end else if (!analog_supply_pin_above_low_i) begin
      state <= pec_pkg::PEC_BACKUP;
    end else begin
      unique case (state)
        pec_pkg::PEC_BACKUP: state <= pec_pkg::PEC_OFF;
        pec_pkg::PEC_OFF: if (start_pending && vsense_above_high_i) begin
          state <= pec_pkg::PEC_ACTIVE;
        end
        pec_pkg::PEC_ACTIVE: if (off_pending) begin
          state <= pec_pkg::PEC_OFF;
        end else if (sleep_req) begin
          state <= pec_pkg::PEC_SLEEP;
        end
        pec_pkg::PEC_SLEEP: if (off_pending) begin
          state <= pec_pkg::PEC_OFF;
        end else if (!sleep_req || fsd_irq_pend) begin
          state <= pec_pkg::PEC_ACTIVE;
        end
      endcase
    end
  end

  // Reset and clocks follow the state
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_o <= pec_pkg::PEC_BACKUP;
      int_rst_n_o <= 1'b0;
      all_clk_en_o <= 1'b0;
      clk32_en_o <= 1'b0;
    end else begin
      state_o <= state;
      int_rst_n_o <= run_state;
      all_clk_en_o <= state == pec_pkg::PEC_ACTIVE;
      clk32_en_o <= run_state;
    end
  end

  // Regulators: analog rail only on demand and only while running
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      always_on_normal_o <= 1'b0;
      analog_ldo_en_o <= 1'b0;
    end else begin
      always_on_normal_o <= state != pec_pkg::PEC_BACKUP;
      analog_ldo_en_o <= analog_demand_i && run_state;
    end
  end

  // Wake functions never stop; turn-on detection only in OFF
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wake_func_en_o <= 1'b1;
      turn_on_detect_en_o <= 1'b0;
    end else begin
      wake_func_en_o <= 1'b1;
      turn_on_detect_en_o <= state == pec_pkg::PEC_OFF;
    end
  end

endmodule // pec_top
